// ==== hdl/ilcr_regs.sv ====
// Interrupt level configuration registers, banks five and six
//
// Overview of operation
// RULE_01: Level zero blocks a source; levels one to seven rank it.
// RULE_02: Bank five bits 26:24 hold source 27 level, read/write, reset zero.
// RULE_03: Bank five bits 18:16 hold source 26 level, read/write, reset zero.
// RULE_04: Bank five bits 10:8 hold source 11 level, read/write, reset zero.
// RULE_05: Bank six bits 26:24 hold source 29 level, read/write, reset zero.
// RULE_06: Bank six bits 18:16 hold source 28 level, read/write, reset zero.
// RULE_07: Bank six bits 10:8 hold source 13 level, read/write, reset zero.
// RULE_08: Reserved bits read zero; writes to them change no level field.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module ilcr_regs
	import ilcr_pkg::*;
#(
	parameter int ADDR_W = ILCR_ADDR_W,
	parameter int DATA_W = ILCR_DATA_W
)
(
	// Clock and reset
	input  wire logic              clock_in,
	input  wire logic              rst_n_in,
	// Register port
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output var  logic [DATA_W-1:0] rdata_out,
	// Levels to the prioritisation logic
	output var  ilcr_levels_t      levels_out,
	output var  logic [5:0]        src_active_out
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// True when the port address names the given register
	function automatic logic addr_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [15:0]       offs
	);
		addr_hit = (addr == ADDR_W'(offs));
	endfunction

	// Pulls a level field out of a write word
	function automatic ilcr_level_t field_of(
		input logic [DATA_W-1:0] word,
		input int                lsb
	);
		field_of = word[lsb +: ILCR_LEVEL_W];
	endfunction

	// Places a level field into an otherwise zero read word
	function automatic logic [DATA_W-1:0] place(
		input ilcr_level_t level,
		input int          lsb
	);
		place = DATA_W'({29'h0000_0000, level}) << lsb;
	endfunction

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	// Register selects for the two banks
	wire logic sel_five;
	wire logic sel_six;
	wire logic wr_five;
	wire logic wr_six;
	wire logic rd_hit;

	assign sel_five = addr_hit(addr_in, ILCR_BANK_FIVE_OFFS);
	assign sel_six  = addr_hit(addr_in, ILCR_BANK_SIX_OFFS);
	assign wr_five  = wr_in & sel_five;
	assign wr_six   = wr_in & sel_six;
	assign rd_hit   = rd_in & (sel_five | sel_six);

	// ----------------------------------------------------------------
	// Write data split into level fields
	// ----------------------------------------------------------------

	// Only the level bit ranges are taken; reserved bits fall away
	wire ilcr_level_t wfield_src27;
	wire ilcr_level_t wfield_src26;
	wire ilcr_level_t wfield_src11;
	wire ilcr_level_t wfield_src29;
	wire ilcr_level_t wfield_src28;
	wire ilcr_level_t wfield_src13;

	assign wfield_src27 = field_of(wdata_in, ILCR_SRC27_LSB); // RULE_02
	assign wfield_src26 = field_of(wdata_in, ILCR_SRC26_LSB); // RULE_03
	assign wfield_src11 = field_of(wdata_in, ILCR_SRC11_LSB); // RULE_04
	assign wfield_src29 = field_of(wdata_in, ILCR_SRC29_LSB); // RULE_05
	assign wfield_src28 = field_of(wdata_in, ILCR_SRC28_LSB); // RULE_06
	assign wfield_src13 = field_of(wdata_in, ILCR_SRC13_LSB); // RULE_07

	// ----------------------------------------------------------------
	// Level field storage
	// ----------------------------------------------------------------

	ilcr_level_t level_src27;
	ilcr_level_t level_src26;
	ilcr_level_t level_src11;
	ilcr_level_t level_src29;
	ilcr_level_t level_src28;
	ilcr_level_t level_src13;
	logic [5:0]  active_vec;

	// Bank five, source 27 (second DMA controller channel 0)
	ilcr_level_field u_src27 (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (wr_five),
		.level_in   (wfield_src27),
		.level_out  (level_src27),
		.active_out (active_vec[3])
	);

	// Bank five, source 26 (second PCI controller)
	ilcr_level_field u_src26 (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (wr_five),
		.level_in   (wfield_src26),
		.level_out  (level_src26),
		.active_out (active_vec[2])
	);

	// Bank five, source 11 (first DMA controller channel 1)
	ilcr_level_field u_src11 (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (wr_five),
		.level_in   (wfield_src11),
		.level_out  (level_src11),
		.active_out (active_vec[0])
	);

	// Bank six, source 29 (second DMA controller channel 2)
	ilcr_level_field u_src29 (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (wr_six),
		.level_in   (wfield_src29),
		.level_out  (level_src29),
		.active_out (active_vec[5])
	);

	// Bank six, source 28 (second DMA controller channel 1)
	ilcr_level_field u_src28 (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (wr_six),
		.level_in   (wfield_src28),
		.level_out  (level_src28),
		.active_out (active_vec[4])
	);

	// Bank six, source 13 (first DMA controller channel 3)
	ilcr_level_field u_src13 (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (wr_six),
		.level_in   (wfield_src13),
		.level_out  (level_src13),
		.active_out (active_vec[1])
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------

	// Assembled bank images; every bit outside a level field is zero
	wire logic [DATA_W-1:0] image_five;
	wire logic [DATA_W-1:0] image_six;
	wire logic [DATA_W-1:0] rdata_sel;
	logic [DATA_W-1:0]      rdata_reg;
	wire logic [DATA_W-1:0] rdata_next;

	assign image_five = place(level_src27, ILCR_SRC27_LSB)  // RULE_02
		| place(level_src26, ILCR_SRC26_LSB)             // RULE_03
		| place(level_src11, ILCR_SRC11_LSB);            // RULE_04
	assign image_six  = place(level_src29, ILCR_SRC29_LSB)  // RULE_05
		| place(level_src28, ILCR_SRC28_LSB)             // RULE_06
		| place(level_src13, ILCR_SRC13_LSB);            // RULE_07

	// Unmapped addresses read as zero
	assign rdata_sel  = sel_five ? image_five // RULE_08
		: (sel_six ? image_six : ILCR_RDATA_RESET);
	// Data stand only in the cycle after the read strobe
	assign rdata_next = rd_hit ? rdata_sel : ILCR_RDATA_RESET;

	// Read data register
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_reg <= ILCR_RDATA_RESET;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, each straight from a flip-flop
	// ----------------------------------------------------------------

	assign rdata_out                       = rdata_reg;
	assign levels_out.priority_field_src29 = level_src29;
	assign levels_out.priority_field_src28 = level_src28;
	assign levels_out.priority_field_src27 = level_src27;
	assign levels_out.priority_field_src26 = level_src26;
	assign levels_out.priority_field_src13 = level_src13;
	assign levels_out.priority_field_src11 = level_src11;
	assign src_active_out                  = active_vec; // RULE_01

endmodule // ilcr_regs

`default_nettype wire

// ==== hdl/ilcr_pkg.sv ====
// Constants and types shared by the interrupt level configuration registers
package ilcr_pkg;

	// ----------------------------------------------------------------
	// Bus and field geometry
	// ----------------------------------------------------------------
	localparam int ILCR_ADDR_W   = 16;
	localparam int ILCR_DATA_W   = 32;
	localparam int ILCR_LEVEL_W  = 3;
	localparam int ILCR_NUM_SRC  = 6;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] ILCR_BANK_FIVE_OFFS = 16'hF624;
	localparam logic [15:0] ILCR_BANK_SIX_OFFS  = 16'hF628;

	// ----------------------------------------------------------------
	// Field positions (least significant bit of each level field)
	// ----------------------------------------------------------------
	localparam int ILCR_SRC27_LSB = 24;
	localparam int ILCR_SRC26_LSB = 16;
	localparam int ILCR_SRC11_LSB = 8;
	localparam int ILCR_SRC29_LSB = 24;
	localparam int ILCR_SRC28_LSB = 16;
	localparam int ILCR_SRC13_LSB = 8;

	// ----------------------------------------------------------------
	// Reset value and level encoding
	// ----------------------------------------------------------------
	localparam logic [2:0] ILCR_LEVEL_RESET    = 3'h0;
	localparam logic [2:0] ILCR_LEVEL_DISABLED = 3'h0;
	localparam logic [2:0] ILCR_LEVEL_MAX      = 3'h7;
	localparam logic [31:0] ILCR_RDATA_RESET   = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [ILCR_LEVEL_W-1:0] ilcr_level_t;

	// Levels handed to the prioritisation logic
	typedef struct packed {
		ilcr_level_t priority_field_src29;
		ilcr_level_t priority_field_src28;
		ilcr_level_t priority_field_src27;
		ilcr_level_t priority_field_src26;
		ilcr_level_t priority_field_src13;
		ilcr_level_t priority_field_src11;
	} ilcr_levels_t;

	// One software access on the register port
	typedef struct packed {
		logic [ILCR_ADDR_W-1:0] addr;
		logic [ILCR_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} ilcr_access_t;

endpackage

// ==== hdl/ilcr_level_field.sv ====
// One 3-bit priority level field with its registered enable flag
`timescale 1ns/10ps
`default_nettype none

module ilcr_level_field
	import ilcr_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	// Write side
	input  wire logic        wr_en_in,
	input  wire ilcr_level_t level_in,
	// Level side
	output var  ilcr_level_t level_out,
	output var  logic        active_out
);

	ilcr_level_t level_reg;
	logic        active_reg;
	wire logic   active_next;

	// A level of zero keeps the source silent; one to seven rank it
	assign active_next = (level_in != ILCR_LEVEL_DISABLED); // RULE_01

	// Level storage; the enable flag follows the same write
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			level_reg  <= ILCR_LEVEL_RESET;
			active_reg <= 1'b0;
		end else if (wr_en_in) begin
			level_reg  <= level_in;
			active_reg <= active_next; // RULE_01
		end
	end

	assign level_out  = level_reg;
	assign active_out = active_reg;

endmodule // ilcr_level_field

`default_nettype wire

// ==== sim/ilcr_regs_chk.sv ====
// Assertion checker for the interrupt level configuration registers
`timescale 1ns/10ps
`default_nettype none

module ilcr_regs_chk
	import ilcr_pkg::*;
#(
	parameter int ADDR_W = ILCR_ADDR_W,
	parameter int DATA_W = ILCR_DATA_W
)
(
	// Clock and reset
	input wire logic              clock_in,
	input wire logic              rst_n_in,
	// Register port
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic              wr_in,
	input wire logic              rd_in,
	input wire logic [DATA_W-1:0] rdata_out,
	// Level side
	input wire ilcr_levels_t      levels_out,
	input wire logic [5:0]        src_active_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	// Decode and the word a read must return
	wire logic        hit5 = (addr_in == ILCR_BANK_FIVE_OFFS);
	wire logic        hit6 = (addr_in == ILCR_BANK_SIX_OFFS);
	wire ilcr_levels_t l = levels_out;
	wire logic [31:0] w5 = {5'h00, l.priority_field_src27, 5'h00, l.priority_field_src26,
		5'h00, l.priority_field_src11, 8'h00};
	wire logic [31:0] w6 = {5'h00, l.priority_field_src29, 5'h00, l.priority_field_src28,
		5'h00, l.priority_field_src13, 8'h00};
	wire logic [31:0] exp_rd = hit5 ? w5 : (hit6 ? w6 : 32'h0000_0000);
	wire logic [5:0]  act = {|l.priority_field_src29, |l.priority_field_src28,
		|l.priority_field_src27, |l.priority_field_src26,
		|l.priority_field_src13, |l.priority_field_src11};

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_src27_write: assert property (
		wr_in && hit5 |=> l.priority_field_src27 == $past(wdata_in[26:24]))
		else $error("source 27 level not taken from write");
	a_src26_write: assert property (
		wr_in && hit5 |=> l.priority_field_src26 == $past(wdata_in[18:16]))
		else $error("source 26 level not taken from write");
	a_src11_write: assert property (
		wr_in && hit5 |=> l.priority_field_src11 == $past(wdata_in[10:8]))
		else $error("source 11 level not taken from write");
	a_src29_write: assert property (
		wr_in && hit6 |=> l.priority_field_src29 == $past(wdata_in[26:24]))
		else $error("source 29 level not taken from write");
	a_src28_write: assert property (
		wr_in && hit6 |=> l.priority_field_src28 == $past(wdata_in[18:16]))
		else $error("source 28 level not taken from write");
	a_src13_write: assert property (
		wr_in && hit6 |=> l.priority_field_src13 == $past(wdata_in[10:8]))
		else $error("source 13 level not taken from write");
	a_active_flags: assert property (
		src_active_out == act)
		else $error("active flags disagree with levels");
	a_levels_hold: assert property (
		!(wr_in && (hit5 || hit6)) |=> $stable(levels_out))
		else $error("levels changed without a bank write");
	a_read_word: assert property (
		rd_in |=> rdata_out == $past(exp_rd))
		else $error("read data wrong");
	a_rdata_idle: assert property (
		!rd_in |=> rdata_out == 32'h0000_0000)
		else $error("read data outside its cycle");

	// Main scenarios reached
	c_write_max: cover property (wr_in && hit5 && wdata_in[26:24] == 3'h7);
	c_read_six: cover property (rd_in && hit6);
	c_write_other: cover property (wr_in && !hit5 && !hit6);

endmodule // ilcr_regs_chk

bind ilcr_regs ilcr_regs_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .levels_out(levels_out),
	.src_active_out(src_active_out));

`default_nettype wire

// ==== sim/ilcr_regs_test.sv ====
// Self-checking testbench for the interrupt level configuration registers
`timescale 1ns/10ps
`default_nettype none

module ilcr_regs_test
	import ilcr_pkg::*;
;
	logic         clock_in;
	logic         rst_n_in;
	logic [15:0]  addr_in;
	logic [31:0]  wdata_in;
	logic         wr_in;
	logic         rd_in;
	logic [31:0]  rdata_out;
	ilcr_levels_t levels_out;
	logic [5:0]   src_active_out;
	logic [31:0]  m5;
	logic [31:0]  m6;
	logic [15:0]  a;
	int           errors;
	int           n_compared;

	ilcr_regs dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.levels_out(levels_out), .src_active_out(src_active_out));

	// 50 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Only the three level fields survive a write
	function automatic logic [31:0] fold(input logic [31:0] d);
		return d & 32'h0707_0700;
	endfunction

	// Word a read of the given address must return
	function automatic logic [31:0] exp_word(input logic [15:0] ad);
		if (ad === ILCR_BANK_FIVE_OFFS) return m5;
		if (ad === ILCR_BANK_SIX_OFFS) return m6;
		return 32'h0000_0000;
	endfunction

	// Level port image for the two model banks, source 29 down to source 11
	function automatic logic [31:0] exp_levels(input logic [31:0] b5, input logic [31:0] b6);
		return {14'h0000, b6[26:24], b6[18:16], b5[26:24], b5[18:16], b6[10:8], b5[10:8]};
	endfunction

	// A source is active exactly when its level is not zero
	function automatic logic [31:0] exp_active(input logic [31:0] b5, input logic [31:0] b6);
		return {26'h0000000, |b6[26:24], |b6[18:16], |b5[26:24], |b5[18:16], |b6[10:8], |b5[10:8]};
	endfunction

	// One bus cycle, driven just after the edge
	task automatic acc(input logic w, input logic r, input logic [15:0] ad, input logic [31:0] d);
		@(posedge clock_in);
		wr_in <= w;
		rd_in <= r;
		addr_in <= ad;
		wdata_in <= d;
	endtask

	task automatic wr(input logic [15:0] ad, input logic [31:0] d);
		acc(1'b1, 1'b0, ad, d);
		if (ad === ILCR_BANK_FIVE_OFFS) m5 = fold(d);
		if (ad === ILCR_BANK_SIX_OFFS) m6 = fold(d);
	endtask

	// Read, then compare read word, levels and active flags
	task automatic rd(input logic [15:0] ad);
		logic [31:0] lv;
		acc(1'b0, 1'b1, ad, 32'h0000_0000);
		acc(1'b0, 1'b0, ad, 32'h0000_0000);
		#1;
		lv = {14'h0000, levels_out};
		check(rdata_out, exp_word(ad));
		check(lv, exp_levels(m5, m6));
		check({26'h0000000, src_active_out}, exp_active(m5, m6));
	endtask

	task automatic test_done();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		errors = 0;
		n_compared = 0;
		m5 = 32'h0;
		m6 = 32'h0;
		rst_n_in = 1'b0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 16'h0000;
		wdata_in = 32'h0;
		void'($urandom(32'h19AD280F));
		repeat (20) @(posedge clock_in);
		rst_n_in <= 1'b1;
		rd(ILCR_BANK_FIVE_OFFS);
		rd(ILCR_BANK_SIX_OFFS);
		// Every level code, reserved bits set, banks written back to back
		for (int v = 0; v < 8; v++) begin
			wr(16'hF624, {5'h1F, v[2:0], 5'h1F, v[2:0], 5'h1F, v[2:0], 8'hFF});
			wr(16'hF628, {5'h1F, ~v[2:0], 5'h1F, v[2:0], 5'h1F, ~v[2:0], 8'hFF});
			rd(16'hF624);
			rd(16'hF628);
		end
		// Random traffic, near misses and unmapped places among it
		for (int i = 0; i < 80; i++) begin
			case ($urandom_range(3))
				0: a = ILCR_BANK_FIVE_OFFS;
				1: a = ILCR_BANK_SIX_OFFS;
				2: a = 16'hF62C;
				default: a = 16'(($urandom()));
			endcase
			if ($urandom_range(1) == 1) wr(a, $urandom());
			else rd(a);
		end
		rd(16'hF624);
		// Reset in mid-run clears all levels
		rst_n_in <= 1'b0;
		m5 = 32'h0;
		m6 = 32'h0;
		repeat (2) @(posedge clock_in);
		rst_n_in <= 1'b1;
		rd(ILCR_BANK_FIVE_OFFS);
		rd(ILCR_BANK_SIX_OFFS);
		test_done();
	end

endmodule // ilcr_regs_test

`default_nettype wire
